// [hw/post_defines.vh]
`ifndef POST_DEFINES_VH
`define POST_DEFINES_VH
// test step timeout, in cycles of core_clk
`define POST_STEP_TIMEOUT 16'h0400
// settle time for the transceiver presence strap after reset release
`define POST_SENSE_SETTLE 4'h8
// fault code field values reported with the verdict
`define POST_CODE_NONE 2'h0
`define POST_CODE_MEM 2'h1
`define POST_CODE_CTRL 2'h2
`define POST_CODE_XCVR 2'h3
`endif

// [hw/post_step_timer.v]
`timescale 1ns/10ps
`include "post_defines.vh"
// counts cycles of one test step and flags a timeout
module post_step_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire clear,
  input wire run,
  // status
  output reg expired
);
  reg [WIDTH-1:0] count;
  always @(posedge core_clk) begin
    if (rst || clear) begin
      count <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (run && !expired) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      if (count == `POST_STEP_TIMEOUT - 16'h0001)
        expired <= 1'b1;
    end
  end
endmodule

// [hw/post_self_test.v]
`timescale 1ns/10ps
`include "post_defines.vh"
// Functional notes
// - self-test starts on its own after every power-up or restart.
// - no self-test outcome is ever written into the error history log.
// - loopback failure: run stays on, error indicator on, network stopped.
// - with no transceiver attached, the transceiver loopback is skipped.
// - skipped transceiver loopback leaves error off and network enabled.
module post_self_test (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // transceiver presence pin, asynchronous
  input wire xcvrPresent,
  // memory test engine
  output reg memTestStart,
  input wire memTestDone,
  input wire memTestPass,
  // controller loopback engine
  output reg ctrlLoopStart,
  input wire ctrlLoopDone,
  input wire ctrlLoopPass,
  // transceiver loopback engine
  output reg xcvrLoopStart,
  input wire xcvrLoopDone,
  input wire xcvrLoopPass,
  // front panel
  output reg runIndicator,
  output reg commErrorIndicator,
  // unit gating
  output reg unitEnable,
  output reg netEnable,
  // verdict
  output reg testBusy,
  output reg testDone,
  output reg xcvrSkipped,
  output reg [1:0] faultCode,
  // error history log write port, never asserted by this block
  output reg logWrite
);
  // -----------------------------------------------------------
  // step encoding, one-hot
  // -----------------------------------------------------------
  localparam [6:0] ST_SETTLE = 7'h01;
  localparam [6:0] ST_MEM = 7'h02;
  localparam [6:0] ST_CTRL = 7'h04;
  localparam [6:0] ST_XCVR = 7'h08;
  localparam [6:0] ST_PASS = 7'h10;
  localparam [6:0] ST_NETFAIL = 7'h20;
  localparam [6:0] ST_HALT = 7'h40;

  // -----------------------------------------------------------
  // presence pin synchroniser
  // -----------------------------------------------------------
  reg sync1;
  reg sync2;
  reg sync3;
  reg present;
  always @(posedge core_clk) begin
    sync1 <= xcvrPresent;
    sync2 <= sync1;
    sync3 <= sync2;
    if (rst)
      present <= 1'b0;
    else if (sync2 == sync3)
      present <= sync3;
  end

  // -----------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------
  reg [6:0] state;
  reg [6:0] next_state;
  reg [3:0] settle;
  reg xcvrAttached;
  wire timedOut;
  wire settled = (settle == `POST_SENSE_SETTLE);
  // the timer restarts on the very edge that enters a new step, so time
  // spent in an earlier step never counts against the next one
  wire stepClear = (next_state != state);

  // true when the coming edge moves the sequencer into the given step
  function isEntering;
    input [6:0] from;
    input [6:0] to;
    input [6:0] step;
    begin
      isEntering = (to == step) && (from != step);
    end
  endfunction

  // a step fails on a failing verdict or when its engine stays silent
  function stepFailed;
    input done;
    input pass;
    input expired;
    begin
      stepFailed = (done && !pass) || expired;
    end
  endfunction

  post_step_timer #(.WIDTH(16)) stepTimer (
    .core_clk(core_clk),
    .rst(rst),
    .clear(stepClear),
    .run(testBusy),
    .expired(timedOut)
  );

  // a stuck engine counts as a failure so the unit never hangs in test
  wire memFail = stepFailed(memTestDone, memTestPass, timedOut);
  wire ctrlFail = stepFailed(ctrlLoopDone, ctrlLoopPass, timedOut);
  wire xcvrFail = stepFailed(xcvrLoopDone, xcvrLoopPass, timedOut);

  always @* begin
    next_state = state;
    case (state)
      ST_SETTLE: begin
        // presence is sampled only once the strap has settled
        if (settled)
          next_state = ST_MEM;
      end
      ST_MEM: begin
        if (memFail)
          next_state = ST_HALT;
        else if (memTestDone)
          next_state = ST_CTRL;
      end
      ST_CTRL: begin
        if (ctrlFail)
          next_state = ST_NETFAIL;
        else if (ctrlLoopDone)
          next_state = xcvrAttached ? ST_XCVR : ST_PASS;
      end
      ST_XCVR: begin
        if (xcvrFail)
          next_state = ST_NETFAIL;
        else if (xcvrLoopDone)
          next_state = ST_PASS;
      end
      ST_PASS: next_state = ST_PASS;
      ST_NETFAIL: next_state = ST_NETFAIL;
      ST_HALT: next_state = ST_HALT;
      default: next_state = ST_SETTLE;
    endcase
  end

  // -----------------------------------------------------------
  // presence latch
  // -----------------------------------------------------------
  // the strap is read once per run: a cable pulled mid-test must not
  // reroute a sequence that is already under way
  always @(posedge core_clk) begin
    if (rst)
      xcvrAttached <= 1'b0;
    else if (state == ST_SETTLE && settled)
      xcvrAttached <= present;
  end

  // -----------------------------------------------------------
  // step control and verdict
  // -----------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      // every reset, power-up or restart, begins a fresh run
      state <= ST_SETTLE;
      settle <= 4'h0;
      memTestStart <= 1'b0;
      ctrlLoopStart <= 1'b0;
      xcvrLoopStart <= 1'b0;
      runIndicator <= 1'b0;
      commErrorIndicator <= 1'b0;
      unitEnable <= 1'b0;
      netEnable <= 1'b0;
      testBusy <= 1'b1;
      testDone <= 1'b0;
      xcvrSkipped <= 1'b0;
      faultCode <= `POST_CODE_NONE;
      logWrite <= 1'b0;
    end else begin
      state <= next_state;
      logWrite <= 1'b0;
      if (state == ST_SETTLE && !settled)
        settle <= settle + 4'h1;
      // one-cycle start pulses on entry to each step
      memTestStart <= isEntering(state, next_state, ST_MEM);
      ctrlLoopStart <= isEntering(state, next_state, ST_CTRL);
      xcvrLoopStart <= isEntering(state, next_state, ST_XCVR);
      if (state == ST_CTRL && next_state == ST_PASS)
        xcvrSkipped <= 1'b1;
      case (next_state)
        ST_PASS: begin
          runIndicator <= 1'b1;
          commErrorIndicator <= 1'b0;
          unitEnable <= 1'b1;
          netEnable <= 1'b1;
          testBusy <= 1'b0;
          testDone <= 1'b1;
        end
        ST_NETFAIL: begin
          runIndicator <= 1'b1;
          commErrorIndicator <= 1'b1;
          unitEnable <= 1'b1;
          netEnable <= 1'b0;
          testBusy <= 1'b0;
          testDone <= 1'b1;
          if (state == ST_CTRL)
            faultCode <= `POST_CODE_CTRL;
          else if (state == ST_XCVR)
            faultCode <= `POST_CODE_XCVR;
        end
        ST_HALT: begin
          runIndicator <= 1'b0;
          commErrorIndicator <= 1'b1;
          unitEnable <= 1'b0;
          netEnable <= 1'b0;
          testBusy <= 1'b0;
          testDone <= 1'b1;
          faultCode <= `POST_CODE_MEM;
        end
        default: begin
          testBusy <= 1'b1;
        end
      endcase
    end
  end
endmodule

// [tb/post_engine_model.sv]
`timescale 1ns/10ps
// one test engine, answers a start pulse dly+1 cycles after sampling it; a unit
// restart also resets the engine, so no stale answer survives it
module post_engine_model (
  // clock and restart
  input wire core_clk,
  input wire rst,
  // request and setup
  input wire start,
  input wire ok,
  input wire [3:0] dly,
  // answer
  output reg done,
  output reg pass
);
  integer cnt = -1;
  initial done = 1'b0;
  initial pass = 1'b0;
  // pass toggles while idle so a stale value never reads as a verdict
  always @(posedge core_clk) begin
    done <= !rst && cnt == 0;
    pass <= cnt == 0 ? ok : ~pass;
    cnt <= rst ? -1 : start ? dly : (cnt >= 0 ? cnt - 1 : -1);
  end
endmodule

// [tb/post_self_test_asserts.sv]
`timescale 1ns/10ps
module post_self_test_asserts (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // presence pin
  input wire xcvrPresent,
  // engine handshakes
  input wire memTestStart,
  input wire memTestDone,
  input wire memTestPass,
  input wire ctrlLoopStart,
  input wire xcvrLoopStart,
  // front panel and gating
  input wire runIndicator,
  input wire commErrorIndicator,
  input wire unitEnable,
  input wire netEnable,
  // verdict
  input wire testDone,
  input wire xcvrSkipped,
  input wire [1:0] faultCode,
  input wire logWrite
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_start; $fell(rst) |-> ##[1:20] memTestStart; endproperty
  property p_nolog; !logWrite; endproperty
  property p_mem; testDone && faultCode == 2'h1 |->
    !runIndicator && commErrorIndicator && !unitEnable; endproperty
  property p_loop; testDone && faultCode[1] |->
    runIndicator && commErrorIndicator && !netEnable; endproperty
  property p_skip; xcvrLoopStart |-> xcvrPresent && !xcvrSkipped; endproperty
  property p_skipok; testDone && xcvrSkipped |->
    !commErrorIndicator && netEnable; endproperty
  property p_order; ctrlLoopStart |-> $past(memTestDone && memTestPass);
  endproperty
  a_start: assert property (p_start) else $error("no start");
  a_nolog: assert property (p_nolog) else $error("log write");
  a_mem: assert property (p_mem) else $error("mem verdict");
  a_loop: assert property (p_loop) else $error("loop verdict");
  a_skip: assert property (p_skip) else $error("skip start");
  a_skipok: assert property (p_skipok) else $error("skip verdict");
  a_order: assert property (p_order) else $error("order");
  c_pass: cover property (testDone && netEnable && !xcvrSkipped);
  c_mem: cover property (testDone && !unitEnable);
  c_skip: cover property (testDone && xcvrSkipped);
  c_netfail: cover property (testDone && faultCode[1]);
endmodule

// [tb/tb_power_on_self_test.sv]
`timescale 1ns/10ps
bind post_self_test post_self_test_asserts post_self_test_asserts_i (
  .core_clk(core_clk),
  .rst(rst),
  .xcvrPresent(xcvrPresent),
  .memTestStart(memTestStart),
  .memTestDone(memTestDone),
  .memTestPass(memTestPass),
  .ctrlLoopStart(ctrlLoopStart),
  .xcvrLoopStart(xcvrLoopStart),
  .runIndicator(runIndicator),
  .commErrorIndicator(commErrorIndicator),
  .unitEnable(unitEnable),
  .netEnable(netEnable),
  .testDone(testDone),
  .xcvrSkipped(xcvrSkipped),
  .faultCode(faultCode),
  .logWrite(logWrite)
);
module tb_power_on_self_test;
  reg core_clk = 1'b0, rst = 1'b1, xcvrPresent = 1'b0;
  reg [2:0] ok = 3'h0;
  reg [3:0] dly = 4'h0;
  reg [5:0] exp;
  reg [5:0] got;
  integer errors = 0, checks = 0, seed = 32'h0000_ba8e, i;
  integer stepLog = 0, expSteps = 0;
  wire memTestStart, ctrlLoopStart, xcvrLoopStart, memTestDone, memTestPass;
  wire ctrlLoopDone, ctrlLoopPass, xcvrLoopDone, xcvrLoopPass, logWrite;
  wire runIndicator, commErrorIndicator, unitEnable, netEnable, testBusy;
  wire testDone, xcvrSkipped;
  wire [1:0] faultCode;
  post_self_test post_self_test_i (
    .core_clk(core_clk),
    .rst(rst),
    .xcvrPresent(xcvrPresent),
    .memTestStart(memTestStart),
    .memTestDone(memTestDone),
    .memTestPass(memTestPass),
    .ctrlLoopStart(ctrlLoopStart),
    .ctrlLoopDone(ctrlLoopDone),
    .ctrlLoopPass(ctrlLoopPass),
    .xcvrLoopStart(xcvrLoopStart),
    .xcvrLoopDone(xcvrLoopDone),
    .xcvrLoopPass(xcvrLoopPass),
    .runIndicator(runIndicator),
    .commErrorIndicator(commErrorIndicator),
    .unitEnable(unitEnable),
    .netEnable(netEnable),
    .testBusy(testBusy),
    .testDone(testDone),
    .xcvrSkipped(xcvrSkipped),
    .faultCode(faultCode),
    .logWrite(logWrite)
  );
  // an absent transceiver never answers
  post_engine_model post_engine_model_i[2:0] (.core_clk(core_clk), .rst(rst),
    .start({xcvrLoopStart & xcvrPresent, ctrlLoopStart, memTestStart}),
    .ok(ok), .dly(dly), .done({xcvrLoopDone, ctrlLoopDone, memTestDone}),
    .pass({xcvrLoopPass, ctrlLoopPass, memTestPass}));
  always #4 core_clk = ~core_clk;
  // step log: one base-4 digit per start pulse, 1 mem, 2 ctrl, 3 xcvr;
  // a pulse held two cycles leaves two digits and is caught, bar a held mem pulse in a run that reaches xcvr
  always @(posedge core_clk) begin
    if (rst) stepLog <= 0;
    else if (memTestStart) stepLog <= stepLog * 4 + 1;
    else if (ctrlLoopStart) stepLog <= stepLog * 4 + 2;
    else if (xcvrLoopStart) stepLog <= stepLog * 4 + 3;
  end
  task chk(input [5:0] e, input [5:0] g);
    begin
      checks = checks + 1;
      if (e !== g) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #100000;
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    // with the first pass of the loop, reset spans five rising edges
    repeat (4) @(posedge core_clk) #1;
    for (i = 0; i < 32; i = i + 1) begin
      rst = 1'b1;
      {xcvrPresent, ok} = i[3:0];
      dly = 4'($random(seed));
      @(posedge core_clk) #1;
      rst = 1'b0;
      if (i[4]) begin
        // restart twelve edges in, during the memory step unless dly is 0
        repeat (12) @(posedge core_clk) #1;
        rst = 1'b1;
        @(posedge core_clk) #1;
        rst = 1'b0;
      end
      repeat (300) if (testDone !== 1'b1) @(posedge core_clk) #1;
      exp = !ok[0] ? 6'h14 : !ok[1] ? 6'h2e : !xcvrPresent ? 6'h0b :
        !ok[2] ? 6'h3e : 6'h0b;
      expSteps = !ok[0] ? 1 : (ok[1] && xcvrPresent) ? 27 : 6;
      got = {faultCode, runIndicator, commErrorIndicator, unitEnable,
        netEnable};
      chk(6'h01, {5'h00, testDone});
      chk(exp, got);
      chk(expSteps[5:0], stepLog[5:0]);
      chk(6'h00, {4'h0, testBusy, logWrite});
      if (ok[0] & ok[1])
        chk({5'h00, !xcvrPresent}, {5'h00, xcvrSkipped});
    end
    report_and_stop;
  end
endmodule
